//--- verilog/pmt_pkg.sv
// Purpose: constants and types shared by the period match timer
// Assumes: 8-bit register port, byte-wide data
// Notes: offsets other than the control register are free choices
package pmt_pkg;
    localparam logic [11:0] OFF_CONTROL = 12'hFCA;
    localparam logic [11:0] OFF_COUNT = 12'hFCB;
    localparam logic [11:0] OFF_PERIOD = 12'hFCC;
    localparam logic [11:0] OFF_FLAG = 12'hFCD;
    localparam logic [11:0] OFF_ENABLE = 12'hFCE;
    localparam int CTL_PRE_LSB = 0;
    localparam int CTL_ON_BIT = 2;
    localparam int CTL_POST_LSB = 3;
    localparam int FLAG_MATCH_BIT = 1;
    localparam logic [7:0] CONTROL_RST = 8'h00;
    localparam logic [7:0] COUNT_RST = 8'h00;
    localparam logic [7:0] PERIOD_RST = 8'hFF;
    localparam logic [7:0] CONTROL_MASK = 8'h7F;
    localparam logic [3:0] PRE_DIV1_LAST = 4'h0;
    localparam logic [3:0] PRE_DIV4_LAST = 4'h3;
    localparam logic [3:0] PRE_DIV16_LAST = 4'hF;
    localparam int INSTR_DIV = 4;

    typedef struct packed {
        logic [3:0] post_sel;
        logic on;
        logic [1:0] pre_sel;
    } pmt_ctrl_t;

    typedef struct packed {
        logic [11:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } pmt_bus_t;
endpackage

//--- verilog/pmt_div_cnt.sv
// Purpose: wrap-around divider counter with sync clear
// Assumes: single clock, synchronous active-low reset
// Notes: done pulses on the step that meets the last value
`timescale 1ns/1ps
`default_nettype none
module pmt_div_cnt #(
    parameter int WIDTH = 4
) (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    // control
    input wire logic clr_i,
    input wire logic step_i,
    input wire logic [WIDTH-1:0] last_i,
    // result
    output logic done_o
);
    initial
    begin
        if (WIDTH < 1)
        begin
            $error("pmt_div_cnt: WIDTH must be positive");
        end
    end

    logic [WIDTH-1:0] cnt_reg;
    logic [WIDTH-1:0] cnt_next;

    always_comb
    begin
        done_o = step_i && (cnt_reg >= last_i);
        cnt_next = cnt_reg;
        if (clr_i)
        begin
            cnt_next = '0;
        end
        else if (done_o)
        begin
            cnt_next = '0;
        end
        else if (step_i)
        begin
            cnt_next = cnt_reg + WIDTH'(1);
        end
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_n_i)
        begin
            cnt_reg <= '0;
        end
        else
        begin
            cnt_reg <= cnt_next;
        end
    end
endmodule // pmt_div_cnt
`default_nettype wire

//--- verilog/pmt_timer.sv
// Purpose: 8-bit period match timer with prescaler and postscaler
// Assumes: register port strobes are one cycle, never both at once
// Notes: clk_sys_i stands for the oscillator; instruction tick is /4
// Function
// - count register increments from zero on each prescaled tick
// - prescale select 00 divides by 1, 01 by 4, 1x by 16
// - count compared with period each cycle; equality is the match
// - prescaled tick after a match the count returns to zero
// - match clocks the postscaler; expiry sets match interrupt flag
// - postscale field bits 6..3 select ratio 1:1 up to 1:16
// - interrupt request raised only while match enable is set
// - count and period registers readable and writable any time
// - reset clears count and loads period with all ones
// - count write, control write or reset clear both scalers
// - control write leaves the count value untouched
// - timer counts only while the on bit is one
// - control bit 7 reads zero and ignores writes
// - match output offered as serial port shift clock source
// - unscaled match output offered to the pwm units
//
// The address-and-strobe port was decided locally.
`timescale 1ns/1ps
`default_nettype none
module pmt_timer (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    // register port
    input wire logic [11:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    // timer outputs
    output logic match_o,
    output logic shift_clk_o,
    output logic irq_o
);
    localparam int PRE_W = 4;
    localparam int POST_W = 4;
    localparam int DIV_W = $clog2(pmt_pkg::INSTR_DIV);

    pmt_pkg::pmt_bus_t bus;
    pmt_pkg::pmt_ctrl_t ctrl_reg;
    pmt_pkg::pmt_ctrl_t ctrl_next;
    logic [7:0] count_reg;
    logic [7:0] count_next;
    logic [7:0] period_reg;
    logic [7:0] period_next;
    logic [7:0] flag_reg;
    logic [7:0] flag_next;
    logic [7:0] enable_reg;
    logic [7:0] enable_next;
    logic [DIV_W-1:0] osc_reg;
    logic [DIV_W-1:0] osc_next;
    logic wrap_reg;
    logic wrap_next;
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;
    logic match_reg;
    logic match_next;
    logic irq_reg;
    logic irq_next;
    logic instr_tick;
    logic pre_step;
    logic pre_done;
    logic post_done;
    logic scaler_clr;
    logic [3:0] pre_last;
    logic wr_ctrl;
    logic wr_count;
    logic raw_match;

    initial
    begin
        if (pmt_pkg::INSTR_DIV != (1 << DIV_W))
        begin
            $error("pmt_timer: instruction divide must be a power of two");
        end
    end

    assign bus = '{addr: reg_addr_i, wdata: reg_wdata_i,
                   wr: reg_wr_i, rd: reg_rd_i};
    assign wr_ctrl = bus.wr && (bus.addr == pmt_pkg::OFF_CONTROL);
    assign wr_count = bus.wr && (bus.addr == pmt_pkg::OFF_COUNT);
    assign scaler_clr = wr_ctrl || wr_count;

    // instruction clock tick, one in four system clocks
    assign instr_tick = (osc_reg == DIV_W'(pmt_pkg::INSTR_DIV - 1));
    assign pre_step = instr_tick && ctrl_reg.on;
    assign raw_match = (count_reg == period_reg);

    always_comb
    begin
        unique case (ctrl_reg.pre_sel)
            2'b00: pre_last = pmt_pkg::PRE_DIV1_LAST;
            2'b01: pre_last = pmt_pkg::PRE_DIV4_LAST;
            2'b10,
            2'b11: pre_last = pmt_pkg::PRE_DIV16_LAST;
        endcase
    end

    pmt_div_cnt #(
        .WIDTH(PRE_W)
    ) u_prescale (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i),
        .clr_i(scaler_clr),
        .step_i(pre_step),
        .last_i(pre_last),
        .done_o(pre_done)
    );

    // postscaler counts the one-cycle match pulse
    pmt_div_cnt #(
        .WIDTH(POST_W)
    ) u_postscale (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i),
        .clr_i(scaler_clr),
        .step_i(wrap_reg),
        .last_i(ctrl_reg.post_sel),
        .done_o(post_done)
    );

    always_comb
    begin
        osc_next = osc_reg + DIV_W'(1);
        ctrl_next = ctrl_reg;
        count_next = count_reg;
        period_next = period_reg;
        enable_next = enable_reg;
        wrap_next = 1'b0;
        if (wr_ctrl)
        begin
            // bit 7 is dropped by the struct width
            ctrl_next = pmt_ctrl_from(bus.wdata);
        end
        if (bus.wr && (bus.addr == pmt_pkg::OFF_PERIOD))
        begin
            period_next = bus.wdata;
        end
        if (bus.wr && (bus.addr == pmt_pkg::OFF_ENABLE))
        begin
            enable_next = bus.wdata;
        end
        if (wr_count)
        begin
            count_next = bus.wdata;
        end
        else if (pre_done && !wr_ctrl)
        begin
            if (raw_match)
            begin
                count_next = pmt_pkg::COUNT_RST;
                wrap_next = 1'b1;
            end
            else
            begin
                count_next = count_reg + 8'h01;
            end
        end
    end

    function automatic pmt_pkg::pmt_ctrl_t pmt_ctrl_from(
        input logic [7:0] v
    );
        pmt_ctrl_from.post_sel = v[pmt_pkg::CTL_POST_LSB +: 4];
        pmt_ctrl_from.on = v[pmt_pkg::CTL_ON_BIT];
        pmt_ctrl_from.pre_sel = v[pmt_pkg::CTL_PRE_LSB +: 2];
    endfunction

    always_comb
    begin
        flag_next = flag_reg;
        if (bus.wr && (bus.addr == pmt_pkg::OFF_FLAG))
        begin
            flag_next = flag_reg & ~bus.wdata;
        end
        if (post_done)
        begin
            flag_next[pmt_pkg::FLAG_MATCH_BIT] = 1'b1;
        end
        flag_next = flag_next & (8'h01 << pmt_pkg::FLAG_MATCH_BIT);
    end

    always_comb
    begin
        // level out while an enabled flag stands
        irq_next = |(flag_next & enable_next);
        match_next = wrap_next;
        rdata_next = 8'h00;
        if (bus.rd)
        begin
            unique case (bus.addr)
                pmt_pkg::OFF_CONTROL:
                    rdata_next = {1'b0, ctrl_reg} & pmt_pkg::CONTROL_MASK;
                pmt_pkg::OFF_COUNT: rdata_next = count_reg;
                pmt_pkg::OFF_PERIOD: rdata_next = period_reg;
                pmt_pkg::OFF_FLAG: rdata_next = flag_reg;
                pmt_pkg::OFF_ENABLE: rdata_next = enable_reg;
                default: rdata_next = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_n_i)
        begin
            ctrl_reg <= pmt_pkg::pmt_ctrl_t'(pmt_pkg::CONTROL_RST[6:0]);
            count_reg <= pmt_pkg::COUNT_RST;
            period_reg <= pmt_pkg::PERIOD_RST;
            flag_reg <= 8'h00;
            enable_reg <= 8'h00;
            osc_reg <= '0;
            wrap_reg <= 1'b0;
            rdata_reg <= 8'h00;
            match_reg <= 1'b0;
            irq_reg <= 1'b0;
        end
        else
        begin
            ctrl_reg <= ctrl_next;
            count_reg <= count_next;
            period_reg <= period_next;
            flag_reg <= flag_next;
            enable_reg <= enable_next;
            osc_reg <= osc_next;
            wrap_reg <= wrap_next;
            rdata_reg <= rdata_next;
            match_reg <= match_next;
            irq_reg <= irq_next;
        end
    end

    assign reg_rdata_o = rdata_reg;
    assign match_o = match_reg;
    assign shift_clk_o = match_reg;
    assign irq_o = irq_reg;
endmodule // pmt_timer
`default_nettype wire

//--- dv/pmt_timer_asserts.sv
// Purpose: port-level checks for the period match timer
// Assumes: bound to pmt_timer, one clock domain
// Notes: register writes are spaced by the bench tasks
`timescale 1ns/1ps
`default_nettype none
module pmt_timer_asserts (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    // register port
    input wire logic [11:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_rdata_o,
    // timer outputs
    input wire logic match_o,
    input wire logic shift_clk_o,
    input wire logic irq_o
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);
    match_pulse_a: assert property (
        match_o |=> !match_o)
        else $error("match pulse too long");
    // instruction ticks come only every fourth clock
    match_gap_a: assert property (
        match_o |=> !match_o [*3])
        else $error("matches too close");
    shift_same_a: assert property (
        shift_clk_o == match_o)
        else $error("shift clock differs from match");
    rdata_idle_a: assert property (
        !$past(reg_rd_i) |-> reg_rdata_o == 8'h00)
        else $error("read data outside read slot");
    ctrl_bit7_a: assert property (
        reg_rd_i && reg_addr_i == pmt_pkg::OFF_CONTROL
        |=> !reg_rdata_o[7])
        else $error("control bit 7 reads one");
    irq_mask_a: assert property (
        reg_wr_i && !reg_wdata_i[1]
        && reg_addr_i == pmt_pkg::OFF_ENABLE |=> ##1 !irq_o)
        else $error("irq while disabled");
    irq_flag_a: assert property (
        irq_o && reg_rd_i
        && reg_addr_i == pmt_pkg::OFF_FLAG |=> reg_rdata_o[1])
        else $error("irq without flag");
    period_rw_a: assert property (
        reg_wr_i && reg_addr_i == pmt_pkg::OFF_PERIOD
        ##2 reg_rd_i && reg_addr_i == pmt_pkg::OFF_PERIOD
        |=> reg_rdata_o == $past(reg_wdata_i, 3))
        else $error("period readback wrong");
endmodule // pmt_timer_asserts
`default_nettype wire

//--- dv/tb.sv
// Purpose: directed bench for the period match timer
// Assumes: strobes one cycle, read data in the following cycle
// Notes: match spacing is measured in clock cycles
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic clk_sys_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [11:0] reg_addr_i = 12'h000;
    logic [7:0] reg_wdata_i = 8'h00;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic [7:0] reg_rdata_o;
    logic match_o;
    logic shift_clk_o;
    logic irq_o;
    logic [7:0] d;
    int error_cnt = 0;
    int samples_checked = 0;
    int cyc = 0;
    int n;
    int k;
    int div[4] = '{1, 4, 16, 16};
    logic [3:0] post[3] = '{4'h0, 4'h1, 4'hF};
    pmt_timer u_pmt_timer (
        .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_rdata_o(reg_rdata_o), .match_o(match_o),
        .shift_clk_o(shift_clk_o), .irq_o(irq_o)
    );
    initial
        forever #5 clk_sys_i = ~clk_sys_i;
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        samples_checked++;
        if (s !== e)
        begin
            error_cnt++;
            $display("FAIL %0t seen %h exp %h", $time, s, e);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] v);
        @(posedge clk_sys_i);
        reg_addr_i <= a;
        reg_wdata_i <= v;
        reg_wr_i <= 1'b1;
        @(posedge clk_sys_i);
        reg_wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a);
        @(posedge clk_sys_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge clk_sys_i);
        reg_rd_i <= 1'b0;
        #1 d = reg_rdata_o;
    endtask
    // n ends as the cycles waited for the next match pulse
    task automatic wm();
        n = 0;
        do
        begin
            @(posedge clk_sys_i);
            #1;
            n++;
        end
        while (match_o !== 1'b1 && n < 999);
    endtask
    task automatic test_done();
        if (error_cnt == 0 && samples_checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    always @(posedge clk_sys_i)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            error_cnt++;
            test_done();
        end
    end
    initial
    begin
        repeat (3) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        rd(pmt_pkg::OFF_COUNT);
        chk(d, 8'h00);
        rd(pmt_pkg::OFF_PERIOD);
        chk(d, 8'hFF);
        wr(pmt_pkg::OFF_CONTROL, 8'hFF);
        rd(pmt_pkg::OFF_CONTROL);
        chk(d, 8'h7F);
        wr(pmt_pkg::OFF_CONTROL, 8'h00);
        wr(pmt_pkg::OFF_COUNT, 8'h05);
        wr(pmt_pkg::OFF_CONTROL, 8'h78);
        repeat (50) @(posedge clk_sys_i);
        rd(pmt_pkg::OFF_COUNT);
        chk(d, 8'h05);
        rd(pmt_pkg::OFF_CONTROL);
        chk(d, 8'h78);
        rd(12'h000);
        chk(d, 8'h00);
        wr(pmt_pkg::OFF_PERIOD, 8'h02);
        rd(pmt_pkg::OFF_PERIOD);
        chk(d, 8'h02);
        wr(pmt_pkg::OFF_COUNT, 8'h00);
        for (int p = 0; p < 4; p++)
        begin
            wr(pmt_pkg::OFF_CONTROL, 8'h04 | 8'(p));
            wm();
            wm();
            chk(n, 12 * div[p]);
        end
        wr(pmt_pkg::OFF_PERIOD, 8'h01);
        wr(pmt_pkg::OFF_CONTROL, 8'h04);
        repeat (40) @(posedge clk_sys_i);
        chk(irq_o, 1'b0);
        rd(pmt_pkg::OFF_FLAG);
        chk(d[1], 1'b1);
        wr(pmt_pkg::OFF_ENABLE, 8'h02);
        repeat (2) @(posedge clk_sys_i);
        chk(irq_o, 1'b1);
        rd(pmt_pkg::OFF_FLAG);
        for (int i = 0; i < 3; i++)
        begin
            wr(pmt_pkg::OFF_CONTROL, 8'h00);
            wr(pmt_pkg::OFF_FLAG, 8'h02);
            wr(pmt_pkg::OFF_CONTROL, {1'b0, post[i], 3'b100});
            chk(irq_o, 1'b0);
            n = 0;
            k = 0;
            // count matches up to the flag, plus a two cycle margin
            while (irq_o !== 1'b1 && k < 600)
            begin
                @(posedge clk_sys_i);
                k++;
                n += (match_o === 1'b1);
            end
            repeat (2)
            begin
                @(posedge clk_sys_i);
                n += (match_o === 1'b1);
            end
            chk(n, post[i] + 1);
        end
        wr(pmt_pkg::OFF_ENABLE, 8'h00);
        repeat (2) @(posedge clk_sys_i);
        chk(irq_o, 1'b0);
        test_done();
    end
endmodule // tb
bind pmt_timer pmt_timer_asserts u_pmt_timer_asserts (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .match_o(match_o),
    .shift_clk_o(shift_clk_o), .irq_o(irq_o)
);
`default_nettype wire
